// ==== hdl/timer_pkg.sv ====
// Shared constants, register map and types for the capture timer core
// Contract
// - Count source comes from the 3-bit select; 110b fast oscillator, 111b its divided clock.
// - With select 101b and pin set as input, count each external clock rising edge.
// - Buffer enable bits pair register C behind A and register D behind B.
// - Buffered capture moves old A or B into its buffer, then captures the counter.
// - Buffered compare or PWM match reloads A or B from its buffer.
// - PWM2 buffered reloads B from D on A match or trigger edge.
// - Buffer registers C and D still set their match flags in compare modes.
// - Buffered capture still sets C or D flag on each C or D pin edge.
// - Filtered inputs accept a new level only after three equal samples.
// - Output disable bits gate pin drive; low cutoff pin sets all four when enabled.
// - Outputs return to port control within one or two clocks after cutoff low.
// - Cutoff pin changes set the interrupt request flag per polarity and edge mode.
// - Capture copies the counter into A to D on the selected pin edge.
// - Register A may capture on slow oscillator divided-by-128 edges instead of its pin.
// - Counter increments; free runs, or clears to zero on capture into A or, in compare modes, on match A.
// - Run bit starts and stops counting; counter holds and stays software accessible. When stopped, a capture into A with CTRL_CLR set still clears it.
// - Capture events and counter overflow raise an interrupt request.
// - Filter sample clock: system divided by 32, by 8, undivided, or count source.
// - Edge codes: 00 rising, 01 falling, 10 both, 11 not permitted.
package timer_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   // Register offsets
   localparam logic [3:0] OFS_CTRL    = 4'h0;
   localparam logic [3:0] OFS_COUNTER = 4'h1;
   localparam logic [3:0] OFS_GR_A    = 4'h2;
   localparam logic [3:0] OFS_GR_B    = 4'h3;
   localparam logic [3:0] OFS_GR_C    = 4'h4;
   localparam logic [3:0] OFS_GR_D    = 4'h5;
   localparam logic [3:0] OFS_EDGE    = 4'h6;
   localparam logic [3:0] OFS_FILTER  = 4'h7;
   localparam logic [3:0] OFS_OUTEN   = 4'h8;
   localparam logic [3:0] OFS_STATUS  = 4'h9;
   localparam logic [3:0] OFS_IRQCFG  = 4'hA;
   // Control fields
   localparam int unsigned CTRL_RUN     = 0;
   localparam int unsigned CTRL_CLR     = 1;
   localparam int unsigned CTRL_CSS_LO  = 2;
   localparam int unsigned CTRL_BFC     = 5;
   localparam int unsigned CTRL_BFD     = 6;
   localparam int unsigned CTRL_MODE_LO = 7;
   localparam int unsigned EDGE_A_SRC   = 8;
   localparam int unsigned FILT_CK_LO   = 6;
   localparam int unsigned OUTEN_CUTOFF = 7;
   localparam int unsigned STAT_OVF     = 4;
   localparam int unsigned STAT_IRQ0    = 5;
   // Reset values
   localparam logic [15:0] RST_CTRL   = 16'h0000;
   localparam logic [15:0] RST_EDGE   = 16'h0100;
   localparam logic [15:0] RST_FILTER = 16'h0000;
   localparam logic [15:0] RST_OUTEN  = 16'h000F;
   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   // Count source codes
   localparam logic [2:0] CSS_F1      = 3'h0;
   localparam logic [2:0] CSS_F2      = 3'h1;
   localparam logic [2:0] CSS_F4      = 3'h2;
   localparam logic [2:0] CSS_F8      = 3'h3;
   localparam logic [2:0] CSS_F32     = 3'h4;
   localparam logic [2:0] CSS_EXT     = 3'h5;
   localparam logic [2:0] CSS_FAST    = 3'h6;
   localparam logic [2:0] CSS_FASTDIV = 3'h7;
   // Prescaler tick indices
   localparam int unsigned PRE_F1  = 0;
   localparam int unsigned PRE_F2  = 1;
   localparam int unsigned PRE_F4  = 2;
   localparam int unsigned PRE_F8  = 3;
   localparam int unsigned PRE_F32 = 4;
   // Filter sample clock codes
   localparam logic [1:0] FCK_F32 = 2'h0;
   localparam logic [1:0] FCK_F8  = 2'h1;
   localparam logic [1:0] FCK_F1  = 2'h2;
   localparam logic [1:0] FCK_SRC = 2'h3;
   // Capture edge codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] EDGE_NONE = 2'h3;
   // Filter depth in samples
   localparam int unsigned FILT_SAMPLES = 3;
   typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_PWM, MODE_PWM2} mode_t;
endpackage

// ==== hdl/clock_prescaler.sv ====
// Free-running divider giving one-cycle ticks at f1, f2, f4, f8 and f32
module clock_prescaler
   import timer_pkg::*;
#(
   parameter int unsigned DIV_BITS = 5
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Ticks
   output logic [4:0]      o_tick
);
   logic [DIV_BITS-1:0] div_reg;

   if (DIV_BITS < 5) begin : g_chk
      $error("clock_prescaler needs DIV_BITS of at least 5");
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   assign o_tick[PRE_F1]  = 1'b1;
   assign o_tick[PRE_F2]  = div_reg[0];
   assign o_tick[PRE_F4]  = &div_reg[1:0];
   assign o_tick[PRE_F8]  = &div_reg[2:0];
   assign o_tick[PRE_F32] = &div_reg[4:0];
endmodule

// ==== hdl/input_filter.sv ====
// Three-flop pin synchroniser with optional three-sample digital filter
module input_filter
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Pin and control
   input  wire logic i_pin,
   input  wire logic i_filt_en,
   input  wire logic i_sample,
   // Conditioned level
   output logic      o_level
);
   logic                    s1_reg;
   logic                    s2_reg;
   logic                    s3_reg;
   logic                    sync_reg;
   logic [FILT_SAMPLES-1:0] samp_reg;
   logic                    filt_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_reg   <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            sync_reg <= s3_reg;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         samp_reg <= '0;
         filt_reg <= 1'b0;
      end else begin
         if (i_sample) begin
            samp_reg <= {samp_reg[FILT_SAMPLES-2:0], sync_reg};
         end
         if (samp_reg == {FILT_SAMPLES{1'b1}}) begin
            filt_reg <= 1'b1;
         end else if (samp_reg == '0) begin
            filt_reg <= 1'b0;
         end
      end
   end

   assign o_level = i_filt_en ? filt_reg : sync_reg;

   AST_FILT_AGREE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (filt_reg != $past(filt_reg)) |-> ($past(samp_reg) == {FILT_SAMPLES{filt_reg}}))
      else $error("filter level changed without three equal samples");
endmodule

// ==== hdl/timer_capture_core.sv ====
// Capture timer core: counter, general registers, buffers, filters and cutoff
module timer_capture_core
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // Capture and count pins
   input  wire logic [3:0]        i_chan_pin,
   input  wire logic              i_trigger_input_pin,
   input  wire logic              i_ext_count_clock_pin,
   input  wire logic              i_ext_clk_is_input,
   // Oscillator sources
   input  wire logic              i_fast_osc_enable,
   input  wire logic              i_fast_osc_tick,
   input  wire logic              i_fast_osc_div_tick,
   input  wire logic              i_slow_osc_div128,
   // Cutoff input, already synchronous
   input  wire logic              i_cutoff_irq_pin_n,
   // Outputs
   output logic [3:0]             o_chan_drive_en,
   output logic                   o_irq_req,
   output logic                   o_irq0_request
);
   logic [15:0] ctrl_reg;
   logic [15:0] counter_reg;
   logic [15:0] gr_reg [4];
   logic [15:0] edge_reg;
   logic [15:0] filter_reg;
   logic [3:0]  disable_reg;
   logic        cutoff_en_reg;
   logic [5:0]  status_reg;
   logic [1:0]  irqcfg_reg;
   logic [15:0] rdata_reg;
   logic [6:0]  prev_reg;
   logic        cutoff_prev_reg;
   logic        irq_reg;
   logic [4:0]  pre_tick;
   logic [6:0]  pin_vec;
   logic [6:0]  filt_en_vec;
   logic [6:0]  lvl;
   logic [6:0]  rise;
   logic [6:0]  fall;
   logic        tick_src;
   logic        count_tick;
   logic        sample;
   logic [3:0]  cap_ev;
   logic [3:0]  match;
   logic        trg_rise;
   logic        clear_ev;
   logic        ovf;
   logic        wr_cnt;
   logic        irq0_set;
   logic [15:0] rd_mux;
   mode_t       mode;
   logic        cap_mode;
   logic        bc;
   logic        bd;
   logic [2:0]  css;

   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      unique case (sel)
         EDGE_RISE: edge_hit = r;
         EDGE_FALL: edge_hit = f;
         EDGE_BOTH: edge_hit = r | f;
         EDGE_NONE: edge_hit = 1'b0;
      endcase
   endfunction

   assign mode     = mode_t'(ctrl_reg[CTRL_MODE_LO +: 2]);
   assign cap_mode = (mode == MODE_CAPTURE);
   assign bc       = ctrl_reg[CTRL_BFC];
   assign bd       = ctrl_reg[CTRL_BFD];
   assign css      = ctrl_reg[CTRL_CSS_LO +: 3];
   assign wr_cnt   = i_wr && (i_addr == OFS_COUNTER);

   clock_prescaler #(
      .DIV_BITS (5)
   ) u_pre (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .o_tick  (pre_tick)
   );

   always_comb begin
      unique case (css)
         CSS_F1:      tick_src = pre_tick[PRE_F1];
         CSS_F2:      tick_src = pre_tick[PRE_F2];
         CSS_F4:      tick_src = pre_tick[PRE_F4];
         CSS_F8:      tick_src = pre_tick[PRE_F8];
         CSS_F32:     tick_src = pre_tick[PRE_F32];
         CSS_EXT:     tick_src = rise[5] & i_ext_clk_is_input;
         CSS_FAST:    tick_src = i_fast_osc_tick & i_fast_osc_enable;
         CSS_FASTDIV: tick_src = i_fast_osc_div_tick & i_fast_osc_enable;
      endcase
   end

   always_comb begin
      unique case (filter_reg[FILT_CK_LO +: 2])
         FCK_F32: sample = pre_tick[PRE_F32];
         FCK_F8:  sample = pre_tick[PRE_F8];
         FCK_F1:  sample = pre_tick[PRE_F1];
         FCK_SRC: sample = tick_src;
      endcase
   end

   assign count_tick  = ctrl_reg[CTRL_RUN] & tick_src;
   // Inputs 0-3 channels, 4 trigger, 5 external clock, 6 slow oscillator
   assign pin_vec     = {i_slow_osc_div128, i_ext_count_clock_pin, i_trigger_input_pin, i_chan_pin};
   assign filt_en_vec = {2'b00, filter_reg[4:0]};

   for (genvar g = 0; g < 7; g++) begin : g_in
      input_filter u_flt (
         .i_clk     (i_clk),
         .i_rst_n   (i_rst_n),
         .i_pin     (pin_vec[g]),
         .i_filt_en (filt_en_vec[g]),
         .i_sample  (sample),
         .o_level   (lvl[g])
      );
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= lvl;
      end
   end

   assign rise     = lvl & ~prev_reg;
   assign fall     = ~lvl & prev_reg;
   assign trg_rise = rise[4];

   // Capture events per channel; A may use the slow oscillator instead
   always_comb begin
      cap_ev[0] = cap_mode && edge_hit(edge_reg[1:0], edge_reg[EDGE_A_SRC] ? rise[0] : rise[6],
                                       edge_reg[EDGE_A_SRC] ? fall[0] : fall[6]);
      for (int i = 1; i < 4; i++) begin
         cap_ev[i] = cap_mode && edge_hit(edge_reg[2*i +: 2], rise[i], fall[i]);
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         match[i] = !cap_mode && count_tick && (counter_reg == gr_reg[i]);
      end
   end

   assign clear_ev = ctrl_reg[CTRL_CLR] && (cap_mode ? cap_ev[0] : match[0]);
   assign ovf      = count_tick && !clear_ev && !wr_cnt && (counter_reg == CNT_MAX);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg   <= RST_CTRL;
         edge_reg   <= RST_EDGE;
         filter_reg <= RST_FILTER;
         irqcfg_reg <= 2'h0;
      end else if (i_wr) begin
         unique case (i_addr)
            OFS_CTRL:   ctrl_reg   <= i_wdata;
            OFS_EDGE:   edge_reg   <= i_wdata;
            OFS_FILTER: filter_reg <= i_wdata;
            OFS_IRQCFG: irqcfg_reg <= i_wdata[1:0];
            default:    ;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         counter_reg <= RST_ZERO;
      end else if (wr_cnt) begin
         counter_reg <= i_wdata;
      end else if (clear_ev) begin
         counter_reg <= RST_ZERO;
      end else if (count_tick) begin
         counter_reg <= counter_reg + 16'h0001;
      end
   end

   // Hardware transfers override a software write in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) begin
            gr_reg[i] <= CNT_MAX;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (i_wr && (i_addr == OFS_GR_A + 4'(i))) begin
               gr_reg[i] <= i_wdata;
            end
         end
         if (cap_mode) begin
            if (cap_ev[0]) begin
               gr_reg[0] <= counter_reg;
            end
            if (cap_ev[1]) begin
               gr_reg[1] <= counter_reg;
            end
            if (bc ? cap_ev[0] : cap_ev[2]) begin
               gr_reg[2] <= bc ? gr_reg[0] : counter_reg;
            end
            if (bd ? cap_ev[1] : cap_ev[3]) begin
               gr_reg[3] <= bd ? gr_reg[1] : counter_reg;
            end
         end else if (mode == MODE_PWM2) begin
            if (bd && (match[0] || trg_rise)) begin
               gr_reg[1] <= gr_reg[3];
            end
         end else begin
            if (bc && match[0]) begin
               gr_reg[0] <= gr_reg[2];
            end
            if (bd && match[1]) begin
               gr_reg[1] <= gr_reg[3];
            end
         end
      end
   end

   // Cutoff pin edge per polarity and edge mode
   always_comb begin
      if (irqcfg_reg[1]) begin
         irq0_set = (i_cutoff_irq_pin_n != cutoff_prev_reg);
      end else if (irqcfg_reg[0]) begin
         irq0_set = i_cutoff_irq_pin_n & ~cutoff_prev_reg;
      end else begin
         irq0_set = ~i_cutoff_irq_pin_n & cutoff_prev_reg;
      end
   end

   // Set wins over a write-one clear
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         status_reg      <= 6'h00;
         cutoff_prev_reg <= 1'b1;
      end else begin
         cutoff_prev_reg <= i_cutoff_irq_pin_n;
         status_reg <= (status_reg & ~((i_wr && i_addr == OFS_STATUS) ? i_wdata[5:0] : 6'h00))
                     | {irq0_set, ovf, cap_ev | match};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         disable_reg   <= RST_OUTEN[3:0];
         cutoff_en_reg <= RST_OUTEN[OUTEN_CUTOFF];
      end else begin
         if (i_wr && i_addr == OFS_OUTEN) begin
            disable_reg   <= i_wdata[3:0];
            cutoff_en_reg <= i_wdata[OUTEN_CUTOFF];
         end
         if (cutoff_en_reg && !i_cutoff_irq_pin_n) begin
            disable_reg <= 4'hF;
         end
      end
   end

   assign o_chan_drive_en = ~disable_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (|cap_ev) | ovf;
      end
   end

   assign o_irq_req      = irq_reg;
   assign o_irq0_request = status_reg[STAT_IRQ0];

   always_comb begin
      rd_mux = 16'h0000;
      unique case (i_addr)
         OFS_CTRL:    rd_mux = ctrl_reg;
         OFS_COUNTER: rd_mux = counter_reg;
         OFS_GR_A:    rd_mux = gr_reg[0];
         OFS_GR_B:    rd_mux = gr_reg[1];
         OFS_GR_C:    rd_mux = gr_reg[2];
         OFS_GR_D:    rd_mux = gr_reg[3];
         OFS_EDGE:    rd_mux = edge_reg;
         OFS_FILTER:  rd_mux = filter_reg;
         OFS_OUTEN:   rd_mux = {8'h00, cutoff_en_reg, 3'h7, disable_reg};
         OFS_STATUS:  rd_mux = {10'h000, status_reg};
         OFS_IRQCFG:  rd_mux = {14'h0000, irqcfg_reg};
         default:     rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= 16'h0000;
      end else if (i_rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign o_rdata = rdata_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_EXT_COUNT: assert property (
      (ctrl_reg[CTRL_RUN] && css == CSS_EXT && rise[5] && i_ext_clk_is_input && !wr_cnt && !clear_ev)
      |=> counter_reg == $past(counter_reg) + 16'h0001)
      else $error("external clock edge did not advance counter");
   AST_FAST_GATE: assert property (
      (css == CSS_FAST && !i_fast_osc_enable) |-> !tick_src)
      else $error("fast oscillator counted while disabled");
   AST_BUF_CAPTURE: assert property (
      (cap_mode && bc && cap_ev[0]) |=> (gr_reg[2] == $past(gr_reg[0])) && (gr_reg[0] == $past(counter_reg)))
      else $error("buffered capture order wrong");
   AST_BUF_COMPARE: assert property (
      (mode == MODE_COMPARE && bc && match[0]) |=> gr_reg[0] == $past(gr_reg[2]))
      else $error("compare match did not reload A from buffer");
   AST_PWM2_TRIG: assert property (
      (mode == MODE_PWM2 && bd && trg_rise) |=> gr_reg[1] == $past(gr_reg[3]))
      else $error("trigger edge did not reload B");
   AST_FLAG_CD: assert property (
      (cap_ev[2] || match[2] || cap_ev[3] || match[3]) |=> |status_reg[3:2])
      else $error("C or D flag not set");
   AST_CUTOFF: assert property (
      (cutoff_en_reg && !i_cutoff_irq_pin_n) |-> ##[1:2] (o_chan_drive_en == 4'h0))
      else $error("cutoff did not disable outputs in time");
   AST_HOLD: assert property (
      (!ctrl_reg[CTRL_RUN] && !wr_cnt && !clear_ev) |=> $stable(counter_reg))
      else $error("counter moved while stopped");
   AST_OVF_WRAP: assert property (
      ovf |=> (counter_reg == 16'h0000) && status_reg[STAT_OVF] && o_irq_req)
      else $error("overflow did not wrap and flag");
   AST_CLEAR_A: assert property (
      (cap_mode && ctrl_reg[CTRL_CLR] && cap_ev[0] && !wr_cnt) |=> counter_reg == 16'h0000)
      else $error("capture into A did not clear counter");

   COV_BUF_CAPTURE: cover property (cap_mode && bc && cap_ev[0]);
   COV_CUTOFF:      cover property (cutoff_en_reg && !i_cutoff_irq_pin_n);
   COV_OVERFLOW:    cover property (ovf);
   COV_PWM2_TRIG:   cover property (mode == MODE_PWM2 && bd && trg_rise);
endmodule

// ==== dv/pin_partner.sv ====
// Far-side pin model: capture pins, external clock, slow oscillator, cutoff pin
module pin_partner (
   // Clock
   input  wire logic       i_clk,
   // Pins towards the core
   output logic [3:0]      o_chan_pin,
   output logic            o_ext_clk,
   output logic            o_slow_osc,
   output logic            o_cutoff_n,
   output logic            o_fast_tick,
   output logic            o_fast_div_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] lvl;
   assign o_chan_pin = lvl[3:0];
   assign o_ext_clk = lvl[4];
   assign o_slow_osc = lvl[5];
   assign o_fast_div_tick = ~o_fast_tick;
   initial begin
      lvl = 6'h00;
      o_cutoff_n = 1'b1;
      o_fast_tick = 1'b0;
   end
   // Fast oscillator ticks every other clock
   always @(posedge i_clk) o_fast_tick <= ~o_fast_tick;
   // Index 4 is the external count clock, 5 the slow oscillator
   task automatic pulse(input int idx, input int hi, input int lo);
      int h;
      h = (idx == 4 && hi < 3) ? 3 : hi;
      @(posedge i_clk) lvl[idx] <= 1'b1;
      repeat (h) @(posedge i_clk);
      lvl[idx] <= 1'b0;
      repeat (lo) @(posedge i_clk);
   endtask
   task automatic cut(input logic v);
      @(posedge i_clk) o_cutoff_n <= v;
   endtask
endmodule

// ==== dv/timer_capture_common_core_tb.sv ====
// Self-checking bench for the capture timer core
module timer_capture_common_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import timer_pkg::*;
   logic clk, rst_n, wr_s, rd_s, ext, ext_in, fast_en, ft, fdt, slow, cut_n, irq, irq0;
   logic [3:0] addr, pins, drv;
   logic [15:0] wdata, rdata, v, a1, a2, m, g;
   logic [15:0] bq[$];
   logic [31:0] seed = 32'hE2D6E3E6;
   int err_count, check_count, irq_n, i0, dv;
   pin_partner p (.i_clk(clk), .o_chan_pin(pins), .o_ext_clk(ext), .o_slow_osc(slow), .o_cutoff_n(cut_n),
      .o_fast_tick(ft), .o_fast_div_tick(fdt));
   timer_capture_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .o_rdata(rdata), .i_chan_pin(pins), .i_trigger_input_pin(pins[0]),
      .i_ext_count_clock_pin(ext), .i_ext_clk_is_input(ext_in), .i_fast_osc_enable(fast_en),
      .i_fast_osc_tick(ft), .i_fast_osc_div_tick(fdt), .i_slow_osc_div128(slow),
      .i_cutoff_irq_pin_n(cut_n), .o_chan_drive_en(drv), .o_irq_req(irq), .o_irq0_request(irq0));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irq_n++;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) begin
         addr <= a;
         wdata <= d;
         wr_s <= 1'b1;
      end
      @(posedge clk) wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk) begin
         addr <= a;
         rd_s <= 1'b1;
      end
      @(posedge clk) rd_s <= 1'b0;
      @(negedge clk) d = rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input string n, input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      results();
   end
   initial begin
      rst_n = 1'b0; addr = 4'h0; wdata = 16'h0000; wr_s = 1'b0; rd_s = 1'b0; ext_in = 1'b0; fast_en = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk("ctrl", OFS_CTRL, RST_CTRL);
      rchk("edge", OFS_EDGE, RST_EDGE);
      rchk("outen", OFS_OUTEN, 16'h007F);
      rchk("unmapped", 4'hF, 16'h0000);
      chk("drive_rst", 16'h0000, {12'h000, drv});
      seed = lfsr(seed);
      wr(OFS_GR_A, seed[15:0]);
      bq.push_back(seed[15:0]);
      rchk("gr_a", OFS_GR_A, seed[15:0]);
      @(posedge clk) fast_en <= 1'b1;
      for (int c = 0; c < 8; c++) if (c != 5) begin
         wr(OFS_COUNTER, 16'h0000);
         wr(OFS_CTRL, {11'h000, c[2:0], 2'b01});
         repeat (80) @(posedge clk);
         wr(OFS_CTRL, {11'h000, c[2:0], 2'b00});
         rd(OFS_COUNTER, v);
         // 82 counted edges per run; a divided source may catch one extra tick
         dv = (c == 4) ? 32 : (c > 5) ? 2 : (1 << c);
         chk("src_count", 16'h0001, {15'h0000, v >= 16'(82 / dv) && v <= 16'(82 / dv + 1)});
         rchk("hold", OFS_COUNTER, v);
      end
      @(posedge clk) ext_in <= 1'b1;
      wr(OFS_COUNTER, 16'h0000);
      wr(OFS_CTRL, 16'h0015);
      repeat (5) p.pulse(4, 3, 3);
      repeat (8) @(posedge clk);
      wr(OFS_CTRL, 16'h0014);
      rchk("ext_count", OFS_COUNTER, 16'h0005);
      wr(OFS_COUNTER, 16'hFFF0);
      wr(OFS_CTRL, 16'h0001);
      repeat (40) @(posedge clk);
      wr(OFS_CTRL, 16'h0000);
      rd(OFS_STATUS, v);
      chk("overflow", 16'h0010, v & 16'h0010);
      rd(OFS_COUNTER, v);
      chk("wrapped", 16'h001A, v);
      wr(OFS_STATUS, 16'h003F);
      wr(OFS_COUNTER, 16'h0000);
      wr(OFS_CTRL, 16'h0021);
      i0 = irq_n;
      p.pulse(0, 4, 10);
      rd(OFS_GR_A, a1);
      rchk("buf_c0", OFS_GR_C, bq[0]);
      bq.push_back(a1);
      p.pulse(0, 4, 10);
      rd(OFS_GR_A, a2);
      rchk("buf_c", OFS_GR_C, bq[1]);
      chk("cap_order", 16'h0001, {15'h0000, a2 > a1});
      chk("cap_irqs", 16'h0002, 16'(irq_n - i0));
      rchk("flag_a", OFS_STATUS, 16'h0001);
      wr(OFS_CTRL, 16'h0001);
      for (int e = 0; e < 4; e++) begin
         wr(OFS_STATUS, 16'h003F);
         wr(OFS_EDGE, 16'h0100 | 16'(e << 2));
         i0 = irq_n;
         fork
            p.pulse(1, 14, 10);
            begin
               repeat (10) @(posedge clk);
               rd(OFS_STATUS, v);
            end
         join
         chk("rise_flag", {14'h0000, e == 0 || e == 2, 1'b0}, v);
         rchk("end_flag", OFS_STATUS, {14'h0000, e != 3, 1'b0});
         chk("edge_irqs", (e == 2) ? 16'h0002 : (e == 3) ? 16'h0000 : 16'h0001, 16'(irq_n - i0));
      end
      wr(OFS_STATUS, 16'h003F);
      wr(OFS_EDGE, 16'h0000);
      wr(OFS_CTRL, 16'h0003);
      p.pulse(5, 4, 10);
      rchk("slow_src", OFS_STATUS, 16'h0001);
      rd(OFS_COUNTER, v);
      chk("clear_a", 16'h0001, {15'h0000, v < 16'h0020});
      wr(OFS_STATUS, 16'h003F);
      wr(OFS_EDGE, 16'h0100);
      wr(OFS_FILTER, 16'h0081);
      p.pulse(0, 2, 12);
      rchk("glitch", OFS_STATUS, 16'h0000);
      p.pulse(0, 6, 12);
      rchk("filtered", OFS_STATUS, 16'h0001);
      // Compare mode: A reloads from C on each match and clears the counter
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_GR_A, 16'h0010);
      wr(OFS_GR_C, 16'h0020);
      wr(OFS_COUNTER, 16'h0000);
      wr(OFS_STATUS, 16'h003F);
      wr(OFS_CTRL, 16'h00A3);
      repeat (60) @(posedge clk);
      wr(OFS_CTRL, 16'h0080);
      m = 16'h0000;
      g = 16'h0010;
      for (int k = 0; k < 62; k++) begin
         if (m == g) begin
            m = 16'h0000;
            g = 16'h0020;
         end else begin
            m++;
         end
      end
      rchk("cmp_count", OFS_COUNTER, m);
      rchk("cmp_reload", OFS_GR_A, g);
      rd(OFS_STATUS, v);
      chk("cmp_flags", 16'h0005, v & 16'h0005);
      seed = lfsr(seed);
      wr(OFS_GR_D, seed[15:0]);
      wr(OFS_CTRL, 16'h01C0);
      p.pulse(0, 4, 10);
      rchk("pwm2_trig", OFS_GR_B, seed[15:0]);
      wr(OFS_IRQCFG, 16'h0000);
      wr(OFS_OUTEN, 16'h0080);
      @(negedge clk) chk("drive_on", 16'h000F, {12'h000, drv});
      p.cut(1'b0);
      repeat (2) @(posedge clk);
      #1 chk("cutoff", 16'h0000, {12'h000, drv});
      chk("irq0", 16'h0001, {15'h0000, irq0});
      p.cut(1'b1);
      rchk("outen_cut", OFS_OUTEN, 16'h00FF);
      results();
   end
endmodule
